/* rtl/dcm_regs.svh */
`ifndef DCM_REGS_SVH
`define DCM_REGS_SVH

`define DCM_CTRL_OFF 8'h00
`define DCM_MULT_OFF 8'h04
`define DCM_STAT_OFF 8'h08
`define DCM_WORD_OFF 8'h0c
`define DCM_IRQ_OFF 8'h10
`define DCM_MASK_OFF 8'h14
`define DCM_CTRL_INT_ON 0
`define DCM_CTRL_EXT_ON 1
`define DCM_CTRL_MON_EN 2
`define DCM_CTRL_SLOW 3
`define DCM_EV_FAIL 0
`define DCM_EV_LOCK 1
`define DCM_EV_UNLOCK 2
`define DCM_CTRL_RST 4'h0
`define DCM_MULT_RST 8'h00
`define DCM_WORD_RST 12'h400
`define DCM_STEP_BIG 12'h020
`define DCM_STEP_MID 12'h008
`define DCM_STEP_FINE 12'h001
`define DCM_DIV_SLOWEST 4'h9
`define DCM_FAIL_REFS 3'h4
`define DCM_RESP_OKAY 2'h0
`define DCM_RESP_SLVERR 2'h2
`endif

/* rtl/dcm_pkg.sv */
package dcm_pkg;
	typedef enum logic [2:0] {
		BAND_LOW = 3'h0, BAND_MID_LO = 3'h1, BAND_NEAR_LO = 3'h2,
		BAND_NEAR_HI = 3'h3, BAND_MID_HI = 3'h4, BAND_HIGH = 3'h5
	} dcm_band_t;
	typedef enum logic [2:0] {MON_OFF = 3'h1, MON_RUN = 3'h2, MON_FAIL = 3'h4} dcm_mon_t;
endpackage

/* rtl/dcm_core_if.sv */
`timescale 1ns/1ps
interface dcm_core_if;
	logic lf_en;
	logic step;
	dcm_pkg::dcm_band_t band;
	logic [11:0] word;
	logic lock;
	logic mon_go;
	logic mon_keep;
	logic base_rise;
	logic ext_rise;
	logic ext_reference_clock_rise;
	logic int_reference_clock_rise;
	logic mon_active;
	logic mon_fail;
	modport lf(input lf_en, step, band, output word, lock);
	modport mon(input mon_go, mon_keep, base_rise, ext_rise, ext_reference_clock_rise, int_reference_clock_rise,
		output mon_active, mon_fail);
endinterface

/* rtl/dcm_loop_filter.sv */
`timescale 1ns/1ps
`include "dcm_regs.svh"
module dcm_loop_filter (
	input wire logic mclk,
	input wire logic rstn,
	dcm_core_if.lf c
);
	logic [11:0] word_reg;
	logic [11:0] word_next;
	logic lock_reg;
	logic lock_next;
	wire big = (c.band == dcm_pkg::BAND_LOW) || (c.band == dcm_pkg::BAND_HIGH);
	wire mid = (c.band == dcm_pkg::BAND_MID_LO) || (c.band == dcm_pkg::BAND_MID_HI);
	wire up = (c.band >= dcm_pkg::BAND_NEAR_HI);
	wire near = (c.band == dcm_pkg::BAND_NEAR_LO) || (c.band == dcm_pkg::BAND_NEAR_HI);
	wire [11:0] mag = big ? `DCM_STEP_BIG : (mid ? `DCM_STEP_MID : `DCM_STEP_FINE);
	// plain 12-bit wrap: carries reach the divider code, no clamp
	wire [11:0] stepped = up ? word_reg + mag : word_reg - mag;
	assign word_next = (c.lf_en && c.step) ? stepped : word_reg;
	assign lock_next = !c.lf_en ? 1'b0 : (c.step ? near : lock_reg);
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			word_reg <= `DCM_WORD_RST;
			lock_reg <= 1'b0;
		end else begin
			word_reg <= word_next;
			lock_reg <= lock_next;
		end
	end
	assign c.word = word_reg;
	assign c.lock = lock_reg;

	big_up_a: assert property (@(posedge mclk) disable iff (!rstn)
		c.lf_en && c.step && c.band == dcm_pkg::BAND_HIGH |=> word_reg == $past(word_reg) + 12'h020)
		else $error("high band step is not +32");
	hold_a: assert property (@(posedge mclk) disable iff (!rstn)
		!c.step |=> $stable(word_reg)) else $error("word changed without comparison");
	carry_only_a: assert property (@(posedge mclk) disable iff (!rstn)
		c.lf_en && c.step && c.band == dcm_pkg::BAND_NEAR_HI && word_reg[7:0] != 8'hff
		|=> word_reg[11:8] == $past(word_reg[11:8])) else $error("divider moved without carry");
	lock_a: assert property (@(posedge mclk) disable iff (!rstn)
		c.lf_en && c.step |=> lock_reg == $past(near)) else $error("lock flag wrong");
endmodule

/* rtl/dcm_clk_monitor.sv */
`timescale 1ns/1ps
`include "dcm_regs.svh"
module dcm_clk_monitor (
	input wire logic mclk,
	input wire logic rstn,
	dcm_core_if.mon m
);
	dcm_pkg::dcm_mon_t st_reg;
	dcm_pkg::dcm_mon_t st_next;
	logic [2:0] bcnt_reg;
	logic [2:0] ecnt_reg;
	// a stopped clock also lets its counter reach four
	wire [2:0] bcnt_next = m.base_rise ? 3'h0 : (m.ext_reference_clock_rise ? bcnt_reg + 3'h1 : bcnt_reg);
	wire [2:0] ecnt_next = m.ext_rise ? 3'h0 : (m.int_reference_clock_rise ? ecnt_reg + 3'h1 : ecnt_reg);
	wire slow = (bcnt_next == `DCM_FAIL_REFS) || (ecnt_next == `DCM_FAIL_REFS);
	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			dcm_pkg::MON_OFF: if (m.mon_go) st_next = dcm_pkg::MON_RUN;
			dcm_pkg::MON_RUN: begin
				if (!m.mon_keep) st_next = dcm_pkg::MON_OFF;
				else if (slow) st_next = dcm_pkg::MON_FAIL;
			end
			dcm_pkg::MON_FAIL: if (!m.mon_keep) st_next = dcm_pkg::MON_OFF;
			default: st_next = dcm_pkg::MON_OFF;
		endcase
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= dcm_pkg::MON_OFF;
			bcnt_reg <= 3'h0;
			ecnt_reg <= 3'h0;
		end else begin
			st_reg <= st_next;
			bcnt_reg <= (st_next == dcm_pkg::MON_RUN) ? bcnt_next : 3'h0;
			ecnt_reg <= (st_next == dcm_pkg::MON_RUN) ? ecnt_next : 3'h0;
		end
	end
	assign m.mon_active = (st_reg != dcm_pkg::MON_OFF);
	assign m.mon_fail = (st_reg == dcm_pkg::MON_FAIL);

	slow_base_a: assert property (@(posedge mclk) disable iff (!rstn)
		st_reg == dcm_pkg::MON_RUN && m.mon_keep && !m.base_rise && m.ext_reference_clock_rise
		&& bcnt_reg == 3'h3 |=> st_reg == dcm_pkg::MON_FAIL) else $error("slow base missed");
	stays_on_a: assert property (@(posedge mclk) disable iff (!rstn)
		st_reg != dcm_pkg::MON_OFF && m.mon_keep |=> st_reg != dcm_pkg::MON_OFF)
		else $error("monitor dropped while kept");
	needs_both_a: assert property (@(posedge mclk) disable iff (!rstn)
		!m.mon_keep |=> st_reg == dcm_pkg::MON_OFF) else $error("monitor on without both on");
endmodule

/* rtl/dcm_top.sv */
`timescale 1ns/1ps
`include "dcm_regs.svh"
module dcm_top (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic generator_stop_signal,
	input wire logic ring_osc_clock,
	input wire logic ext_clock_in,
	input wire logic ext_reference_clock,
	input wire logic int_reference_clock,
	input wire logic [2:0] cmp_band,
	input wire logic cmp_done,
	input wire logic int_clock_stable_flag,
	input wire logic ext_clock_stable_flag,
	output logic int_generator_enable,
	output logic ext_generator_enable,
	output logic amp_enable,
	output logic input_path_enable,
	output logic slow_crystal_select,
	output logic internal_clock,
	output logic base_clock,
	output logic external_clock,
	output logic [3:0] osc_divider_code,
	output logic [7:0] osc_stage_code,
	output logic [3:0] osc_divider_decoded,
	output logic filter_lock_flag,
	output logic monitor_fail,
	output logic irq
);
	localparam int NS = 10;

	dcm_core_if core ();

	// pin synchronisers; stage one feeds only stage two
	wire [NS-1:0] pins = {cmp_done, cmp_band, int_reference_clock, ext_reference_clock,
		ext_clock_in, ring_osc_clock, int_clock_stable_flag, ext_clock_stable_flag};
	logic [NS-1:0] s1_reg;
	logic [NS-1:0] s2_reg;
	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++) begin : g_sync
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					s1_reg[gi] <= 1'b0;
					s2_reg[gi] <= 1'b0;
				end else begin
					s1_reg[gi] <= pins[gi];
					s2_reg[gi] <= s1_reg[gi];
				end
			end
		end
	endgenerate

	wire ext_st_s = s2_reg[0];
	wire int_st_s = s2_reg[1];
	wire ick_s = s2_reg[2];
	wire eck_s = s2_reg[3];
	wire ext_reference_clock_s = s2_reg[4];
	wire int_reference_clock_s = s2_reg[5];
	wire [2:0] band_s = s2_reg[8:6];
	wire done_s = s2_reg[9];

	// edge history of the synchronised pins and of the gated base and external clocks
	logic done_d_reg;
	logic ick_d_reg;
	logic ext_reference_clock_d_reg;
	logic int_reference_clock_d_reg;
	logic base_d_reg;
	logic eck_d_reg;

	// control registers
	logic [3:0] ctrl_reg;
	logic [7:0] mult_reg;
	logic [2:0] mask_reg;
	logic [2:0] istat_reg;
	logic [2:0] istat_next;
	logic irq_reg;

	// gated clocks and enables
	logic int_en_reg;
	logic ext_en_reg;
	logic ick_reg;
	logic eck_reg;
	logic base_reg;
	logic base_next;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic [3:0] dec_reg;
	logic lock_d_reg;
	logic fail_d_reg;

	wire int_on = ctrl_reg[`DCM_CTRL_INT_ON];
	wire ext_on = ctrl_reg[`DCM_CTRL_EXT_ON];
	wire int_en_w = int_on && !generator_stop_signal;
	wire ext_en_w = ext_on && !generator_stop_signal;

	// base divider counts rising edges of the ring oscillator
	wire ick_rise = ick_s && !ick_d_reg;
	wire bypass = (mult_reg <= 8'h01);
	wire [7:0] last = mult_reg - 8'h01;
	wire [7:0] half = {1'b0, mult_reg[7:1]};
	always_comb begin
		cnt_next = cnt_reg;
		if (!int_en_w || bypass)
			cnt_next = 8'h00;
		else if (ick_rise)
			cnt_next = (cnt_reg >= last) ? 8'h00 : cnt_reg + 8'h01;
	end
	always_comb begin
		base_next = 1'b0;
		if (int_en_w && bypass)
			base_next = ick_s;
		else if (int_en_w)
			base_next = (cnt_next < half);
	end

	// one comparison result per completed comparison pulse
	assign core.step = done_s && !done_d_reg;
	assign core.band = dcm_pkg::dcm_band_t'(band_s);
	assign core.lf_en = int_en_reg;
	assign core.base_rise = base_reg && !base_d_reg;
	assign core.ext_rise = eck_reg && !eck_d_reg;
	assign core.ext_reference_clock_rise = ext_reference_clock_s && !ext_reference_clock_d_reg;
	assign core.int_reference_clock_rise = int_reference_clock_s && !int_reference_clock_d_reg;
	// stable flags gate only the start; keep looks at the monitor enable and on bits alone
	assign core.mon_keep = ctrl_reg[`DCM_CTRL_MON_EN] && int_on && ext_on;
	assign core.mon_go = core.mon_keep && int_st_s && ext_st_s;

	dcm_loop_filter u_lf (
		.mclk(mclk),
		.rstn(rstn),
		.c(core)
	);

	dcm_clk_monitor u_mon (
		.mclk(mclk),
		.rstn(rstn),
		.m(core)
	);

	// codes a..f run the oscillator at its slowest setting
	wire [3:0] div_w = core.word[11:8];
	wire [3:0] dec_w = (div_w > `DCM_DIV_SLOWEST) ? `DCM_DIV_SLOWEST : div_w;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			done_d_reg <= 1'b0;
			ick_d_reg <= 1'b0;
			ext_reference_clock_d_reg <= 1'b0;
			int_reference_clock_d_reg <= 1'b0;
			base_d_reg <= 1'b0;
			eck_d_reg <= 1'b0;
		end else begin
			done_d_reg <= done_s;
			ick_d_reg <= ick_s;
			ext_reference_clock_d_reg <= ext_reference_clock_s;
			int_reference_clock_d_reg <= int_reference_clock_s;
			base_d_reg <= base_reg;
			eck_d_reg <= eck_reg;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			int_en_reg <= 1'b0;
			ext_en_reg <= 1'b0;
			ick_reg <= 1'b0;
			eck_reg <= 1'b0;
			base_reg <= 1'b0;
			cnt_reg <= 8'h00;
			dec_reg <= 4'h0;
		end else begin
			int_en_reg <= int_en_w;
			ext_en_reg <= ext_en_w;
			ick_reg <= ick_s && int_en_w;
			eck_reg <= eck_s && ext_en_w;
			base_reg <= base_next;
			cnt_reg <= cnt_next;
			dec_reg <= dec_w;
		end
	end

	// ---- AXI4-Lite slave: one write and one read in flight
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [7:0] aw_addr_reg;
	logic [7:0] w_data_reg;
	logic w_strb0_reg;

	wire aw_take = s_axi_awvalid && awready_reg;
	wire w_take = s_axi_wvalid && wready_reg;
	wire wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
	wire aw_hold_next = (aw_hold_reg || aw_take) && !wr_fire;
	wire w_hold_next = (w_hold_reg || w_take) && !wr_fire;
	wire bvalid_next = wr_fire || (bvalid_reg && !s_axi_bready);
	wire ar_take = s_axi_arvalid && arready_reg;
	wire rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);

	wire [7:0] wa = {aw_addr_reg[7:2], 2'h0};
	wire [7:0] ra = {s_axi_araddr[7:2], 2'h0};
	// only byte lane 0 carries register bits
	wire wr_en = wr_fire && w_strb0_reg;
	wire wr_ctrl = wr_en && (wa == `DCM_CTRL_OFF);
	wire wr_mult = wr_en && (wa == `DCM_MULT_OFF);
	wire wr_mask = wr_en && (wa == `DCM_MASK_OFF);
	wire wa_ok = (wa == `DCM_CTRL_OFF) || (wa == `DCM_MULT_OFF) || (wa == `DCM_STAT_OFF)
		|| (wa == `DCM_WORD_OFF) || (wa == `DCM_IRQ_OFF) || (wa == `DCM_MASK_OFF);
	wire ra_ok = (ra == `DCM_CTRL_OFF) || (ra == `DCM_MULT_OFF) || (ra == `DCM_STAT_OFF)
		|| (ra == `DCM_WORD_OFF) || (ra == `DCM_IRQ_OFF) || (ra == `DCM_MASK_OFF);

	wire [31:0] stat_w = {25'h0, ext_en_reg, int_en_reg, core.mon_fail, core.mon_active,
		ext_st_s, int_st_s, core.lock};
	wire [31:0] rd_w = (ra == `DCM_CTRL_OFF) ? {28'h0, ctrl_reg} :
		(ra == `DCM_MULT_OFF) ? {24'h0, mult_reg} :
		(ra == `DCM_STAT_OFF) ? stat_w :
		(ra == `DCM_WORD_OFF) ? {20'h0, core.word} :
		(ra == `DCM_IRQ_OFF) ? {29'h0, istat_reg} :
		(ra == `DCM_MASK_OFF) ? {29'h0, mask_reg} : 32'h0;

	// sticky events; an event in the clearing read's cycle survives it
	wire [2:0] ev;
	assign ev[`DCM_EV_FAIL] = core.mon_fail && !fail_d_reg;
	assign ev[`DCM_EV_LOCK] = core.lock && !lock_d_reg;
	assign ev[`DCM_EV_UNLOCK] = !core.lock && lock_d_reg;
	wire rd_clr = ar_take && (ra == `DCM_IRQ_OFF);
	assign istat_next = (rd_clr ? 3'h0 : istat_reg) | ev;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
		end else begin
			awready_reg <= !aw_hold_next;
			wready_reg <= !w_hold_next;
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			bvalid_reg <= bvalid_next;
			arready_reg <= !rvalid_next;
			rvalid_reg <= rvalid_next;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			aw_addr_reg <= 8'h00;
			w_data_reg <= 8'h00;
			w_strb0_reg <= 1'b0;
			bresp_reg <= `DCM_RESP_OKAY;
			rresp_reg <= `DCM_RESP_OKAY;
			rdata_reg <= 32'h0;
		end else begin
			if (aw_take)
				aw_addr_reg <= s_axi_awaddr;
			if (w_take) begin
				w_data_reg <= s_axi_wdata[7:0];
				w_strb0_reg <= s_axi_wstrb[0];
			end
			if (wr_fire)
				bresp_reg <= wa_ok ? `DCM_RESP_OKAY : `DCM_RESP_SLVERR;
			if (ar_take) begin
				rdata_reg <= rd_w;
				rresp_reg <= ra_ok ? `DCM_RESP_OKAY : `DCM_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= `DCM_CTRL_RST;
			mult_reg <= `DCM_MULT_RST;
			mask_reg <= 3'h0;
			istat_reg <= 3'h0;
			irq_reg <= 1'b0;
			lock_d_reg <= 1'b0;
			fail_d_reg <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= w_data_reg[3:0];
			if (wr_mult)
				mult_reg <= w_data_reg;
			if (wr_mask)
				mask_reg <= w_data_reg[2:0];
			istat_reg <= istat_next;
			irq_reg <= |(istat_next & mask_reg);
			lock_d_reg <= core.lock;
			fail_d_reg <= core.mon_fail;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign int_generator_enable = int_en_reg;
	assign ext_generator_enable = ext_en_reg;
	// amplifier and input path share the external enable
	assign amp_enable = ext_en_reg;
	assign input_path_enable = ext_en_reg;
	assign slow_crystal_select = ctrl_reg[`DCM_CTRL_SLOW];
	assign internal_clock = ick_reg;
	assign base_clock = base_reg;
	assign external_clock = eck_reg;
	assign osc_divider_code = core.word[11:8];
	assign osc_stage_code = core.word[7:0];
	assign osc_divider_decoded = dec_reg;
	assign filter_lock_flag = core.lock;
	assign monitor_fail = core.mon_fail;
	assign irq = irq_reg;

	amp_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
		amp_enable == $past(ext_on && !generator_stop_signal))
		else $error("amplifier enable wrong");
	int_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
		!int_en_reg |-> !internal_clock && !base_clock)
		else $error("internal clocks not low while disabled");
	ext_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
		generator_stop_signal |=> !ext_generator_enable && !external_clock)
		else $error("external side runs in stop");
	base_pass_a: assert property (@(posedge mclk) disable iff (!rstn)
		int_en_w && bypass |=> base_reg == $past(ick_s))
		else $error("base not passed through");
	mon_accept_a: assert property (@(posedge mclk) disable iff (!rstn)
		!core.mon_active && !(int_st_s && ext_st_s) |=> !core.mon_active)
		else $error("monitor started while unstable");
	dec_slow_a: assert property (@(posedge mclk) disable iff (!rstn)
		core.word[11:8] >= 4'ha |=> osc_divider_decoded == 4'h9)
		else $error("high divider code not decoded as slowest");
endmodule

/* tb/dcm_xtal_model.sv */
`timescale 1ns/1ps
module dcm_xtal_model #(
	parameter bit SLOW_XTAL = 1'b0,
	parameter int HALF_NS = 250
) (
	input wire logic amp_enable,
	input wire logic input_path_enable,
	input wire logic slow_crystal_select,
	input wire logic stall,
	output logic clk_out
);
	// a crystal only swings with the amplifier on and the gain matching its range
	wire run = amp_enable && input_path_enable && slow_crystal_select == SLOW_XTAL;
	initial clk_out = 1'b0;
	// a dead or disabled source leaves the buffered path low, never the last level
	always begin
		#HALF_NS;
		clk_out = (run && !stall) ? ~clk_out : 1'b0;
	end
endmodule

/* tb/test_dcm_top.sv */
`timescale 1ns/1ps
`include "dcm_regs.svh"
module test_dcm_top;
	logic mclk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, tick;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, osc_divider_code, osc_divider_decoded;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic generator_stop_signal, ring_osc_clock, ext_clock_in, ext_reference_clock;
	logic int_reference_clock, cmp_done, int_clock_stable_flag, ext_clock_stable_flag;
	logic [2:0] cmp_band;
	logic int_generator_enable, ext_generator_enable, amp_enable, input_path_enable;
	logic slow_crystal_select, internal_clock, base_clock, external_clock, filter_lock_flag;
	logic monitor_fail, irq, ring_run, xtal_stall;
	logic [7:0] osc_stage_code;
	logic [11:0] exp_word;
	int num_errors, n_checks;

	dcm_top i_dcm_top (.mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .generator_stop_signal, .ring_osc_clock, .ext_clock_in, .ext_reference_clock,
		.int_reference_clock, .cmp_band, .cmp_done, .int_clock_stable_flag, .ext_clock_stable_flag,
		.int_generator_enable, .ext_generator_enable, .amp_enable, .input_path_enable,
		.slow_crystal_select, .internal_clock, .base_clock, .external_clock, .osc_divider_code,
		.osc_stage_code, .osc_divider_decoded, .filter_lock_flag, .monitor_fail, .irq);
	dcm_xtal_model i_dcm_xtal_model (.amp_enable, .input_path_enable, .slow_crystal_select,
		.stall(xtal_stall), .clk_out(ext_clock_in));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// ring and references paced from mclk so the synchronisers always see them
	always @(posedge mclk) begin
		tick <= tick + 8'h01;
		if (tick[1:0] == 2'h3) ring_osc_clock <= ring_run & ~ring_osc_clock;
		if (tick[4:0] == 5'h1f) ext_reference_clock <= ~ext_reference_clock;
		if (tick[4:0] == 5'h0f) int_reference_clock <= ~int_reference_clock;
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		chk(s_axi_bresp, er, "write resp");
		s_axi_bready <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		chk(s_axi_rdata & m, e, "read data");
		chk(s_axi_rresp, er, "read resp");
		s_axi_rready <= 1'b0;
	endtask

	task automatic lf_step(input logic [2:0] b, input logic [11:0] delta, input logic lock);
		@(posedge mclk);
		cmp_band <= b;
		repeat (3) @(posedge mclk);
		cmp_done <= 1'b1;
		// held for several cycles: still one comparison, so one step
		repeat (4) @(posedge mclk);
		cmp_done <= 1'b0;
		repeat (6) @(posedge mclk);
		exp_word = exp_word + delta;
		chk({osc_divider_code, osc_stage_code}, exp_word, "word");
		chk(filter_lock_flag, lock, "lock flag");
	endtask

	task automatic t_regs();
		chk({osc_divider_code, osc_stage_code}, 12'h400, "reset word");
		rchk(`DCM_CTRL_OFF, 32'hff, 32'h0, 2'h0);
		rchk(`DCM_WORD_OFF, 32'hfff, 32'h400, 2'h0);
		wchk(`DCM_MULT_OFF, 32'ha5, 2'h0);
		rchk(`DCM_MULT_OFF, 32'hff, 32'ha5, 2'h0);
		wchk(`DCM_WORD_OFF, 32'hfff, 2'h0);
		rchk(`DCM_WORD_OFF, 32'hfff, 32'h400, 2'h0);
		wchk(8'h18, 32'h1, 2'h2);
		rchk(8'h18, 32'hffffffff, 32'h0, 2'h2);
	endtask

	task automatic t_enables();
		for (int i = 0; i < 8; i++) begin
			wchk(`DCM_CTRL_OFF, i & 3, 2'h0);
			@(posedge mclk);
			generator_stop_signal <= i[2];
			repeat (8) @(posedge mclk);
			chk(int_generator_enable, i[0] & ~i[2], "int enable");
			chk(ext_generator_enable, i[1] & ~i[2], "ext enable");
			chk(amp_enable, i[1] & ~i[2], "amplifier");
			chk(input_path_enable, i[1] & ~i[2], "input path");
			if (!(i[0] & ~i[2])) chk(internal_clock | base_clock, 0, "int clocks");
			if (!(i[1] & ~i[2])) chk(external_clock, 0, "ext clock");
		end
		@(posedge mclk);
		generator_stop_signal <= 1'b0;
	endtask

	task automatic t_divider();
		int ni, nb, dv;
		logic pi, pb;
		int ns[3] = '{0, 1, 3};
		foreach (ns[k]) begin
			wchk(`DCM_MULT_OFF, ns[k], 2'h0);
			{ni, nb, pi, pb} = '0;
			repeat (240) @(posedge mclk) begin
				if (internal_clock && !pi) ni++;
				if (base_clock && !pb) nb++;
				pi = internal_clock;
				pb = base_clock;
			end
			dv = ns[k] > 1 ? ns[k] : 1;
			chk(nb * dv + dv >= ni && nb * dv <= ni + dv && ni > 20, 1, "base rate");
		end
		wchk(`DCM_MULT_OFF, 32'h0, 2'h0);
	endtask

	task automatic t_filter();
		logic [11:0] steps[6] = '{12'hfe0, 12'hff8, 12'hfff, 12'h001, 12'h008, 12'h020};
		exp_word = 12'h400;
		for (int b = 0; b < 6; b++) lf_step(3'(b), steps[b], b == 2 || b == 3);
		chk(irq, 0, "masked irq");
		wchk(`DCM_MASK_OFF, 32'h2, 2'h0);
		repeat (3) @(posedge mclk);
		chk(irq, 1, "irq raised");
		rchk(`DCM_IRQ_OFF, 32'h7, 32'h6, 2'h0);
		repeat (3) @(posedge mclk);
		chk(irq, 0, "irq cleared");
		// push below zero: wraps into the divider codes above nine
		repeat (33) lf_step(3'h0, 12'hfe0, 1'b0);
		chk(osc_divider_decoded, 4'h9, "decoded slowest");
		lf_step(3'h5, 12'h020, 1'b0);
		chk(osc_divider_decoded, 4'h0, "decoded recovered");
	endtask

	task automatic t_monitor();
		wchk(`DCM_MASK_OFF, 32'h1, 2'h0);
		wchk(`DCM_CTRL_OFF, 32'h7, 2'h0);
		repeat (20) @(posedge mclk);
		rchk(`DCM_STAT_OFF, 32'h8, 32'h0, 2'h0);
		ext_clock_stable_flag <= 1'b1;
		repeat (10) @(posedge mclk);
		rchk(`DCM_STAT_OFF, 32'h8, 32'h8, 2'h0);
		int_clock_stable_flag <= 1'b0;
		repeat (400) @(posedge mclk);
		chk(monitor_fail, 0, "healthy clocks");
		rchk(`DCM_STAT_OFF, 32'h8, 32'h8, 2'h0);
		xtal_stall <= 1'b1;
		for (int k = 0; k < 800 && monitor_fail !== 1'b1; k++) @(posedge mclk);
		chk(monitor_fail, 1, "stopped ext clock");
		repeat (3) @(posedge mclk);
		chk(irq, 1, "fail irq");
		rchk(`DCM_IRQ_OFF, 32'h1, 32'h1, 2'h0);
		repeat (3) @(posedge mclk);
		chk(irq, 0, "fail irq cleared");
		xtal_stall <= 1'b0;
		wchk(`DCM_CTRL_OFF, 32'h5, 2'h0);
		repeat (4) @(posedge mclk);
		rchk(`DCM_STAT_OFF, 32'h8, 32'h0, 2'h0);
		// a dead ring oscillator must trip the monitor too
		ring_run <= 1'b0;
		int_clock_stable_flag <= 1'b1;
		wchk(`DCM_CTRL_OFF, 32'h7, 2'h0);
		for (int k = 0; k < 800 && monitor_fail !== 1'b1; k++) @(posedge mclk);
		chk(monitor_fail, 1, "stopped base clock");
		// wrong gain setting: the crystal never starts
		wchk(`DCM_CTRL_OFF, 32'hb, 2'h0);
		repeat (20) @(posedge mclk);
		chk(slow_crystal_select, 1, "slow select");
		chk(external_clock, 0, "wrong gain");
		rchk(`DCM_CTRL_OFF, 32'hf, 32'hb, 2'h0);
	endtask

	initial begin
		{rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, tick, cmp_band, cmp_done} = '0;
		{generator_stop_signal, ring_osc_clock, ext_reference_clock, int_reference_clock} = '0;
		{ext_clock_stable_flag, xtal_stall, num_errors, n_checks} = '0;
		{int_clock_stable_flag, ring_run} = 2'h3;
		s_axi_wstrb = 4'hf;
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		repeat (2) @(posedge mclk);
		t_regs();
		t_enables();
		t_divider();
		t_filter();
		t_monitor();
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		print_verdict();
	end
endmodule
